//--- rtl/osc_tune_cfg.svh
// offsets, field positions, reset values and timing counts of the oscillator block
`ifndef OSC_TUNE_CFG_SVH
`define OSC_TUNE_CFG_SVH

`define CLK_PERIOD_NS   10
`define BIAS_SETTLE_NS  10000
`define BIAS_SETTLE_CYC (`BIAS_SETTLE_NS / `CLK_PERIOD_NS)
`define PU_DELAY_4_MS   4
`define PU_DELAY_16_MS  16
`define PU_DELAY_64_MS  64
`define NS_PER_MS       1000000
`define PU_DELAY_CYC(ms) ((ms) * `NS_PER_MS / `CLK_PERIOD_NS)
`define PIN_FILTER_NS   200
`define PIN_FILTER_CYC  (`PIN_FILTER_NS / `CLK_PERIOD_NS)

`define OSC_FAST_RC     3'h0
`define PM_EXT_CLOCK    2'h0
`define PM_CRYSTAL      2'h2
`define SWM_ALL_ON      2'h0
`define LFSR_SEED       15'h0001
`define CLOCK_FAIL_VEC  24'h000004

`define CAUSE_POR       0
`define CAUSE_EXT       1
`define CAUSE_SLEEP     2
`define CAUSE_WDOG      3
`define CAUSE_SOFT      4
`define CAUSE_TRAP      5
`define CAUSE_ILLEGAL   6
`define CAUSE_POR_ONLY  7'h01

`endif

//--- rtl/osc_tune_pkg.sv
// types shared by the oscillator control module and the reset pin filter
package osc_tune_pkg;

  typedef enum logic [2:0] {
    RS_RUN, RS_BIAS, RS_DELAY, RS_HOLD, RS_WAIT_PHASE
  } rst_state_e;

  typedef struct packed {
    logic [5:0]  roll;
    logic [14:0] lfsr;
    logic [3:0]  trim;
    logic        rangeHigh;
    logic        fastPower;
    logic [2:0]  currentOsc;
    logic        clockFail;
    logic        switchReq;
    logic        targetPrimary;
    logic        failForced;
    logic        primaryOff;
    logic        trap;
    logic [23:0] trapVector;
    rst_state_e  rstState;
    logic [22:0] cnt;
    logic        system_reset;
    logic [6:0]  cause;
    logic        pinOut;
    logic        pinOe;
  } ctrl_s;

  typedef struct packed {
    logic       level;
    logic [7:0] cnt;
  } filt_s;

endpackage

//--- rtl/reset_filter_if.sv
// carrier between the controller and the reset pin noise filter
`timescale 1ns/1ps
`default_nettype none
interface reset_filter_if;
  logic rawPinN;
  logic pinActive;
  modport filt (input rawPinN, output pinActive);
  modport ctrl (output rawPinN, input pinActive);
endinterface
`default_nettype wire

//--- rtl/reset_pin_filter.sv
// noise filter on the external reset pin: rejects pulses shorter than the window
`timescale 1ns/1ps
`default_nettype none
`include "osc_tune_cfg.svh"
module reset_pin_filter (
  input  wire logic           ref_clk,
  input  wire logic           reset,
  reset_filter_if.filt        pin
);

  osc_tune_pkg::filt_s st;
  osc_tune_pkg::filt_s next_st;

  // level follows the pin only after it stayed changed for the whole window
  always_comb begin
    next_st = st;
    if ((!pin.rawPinN) == st.level) begin
      next_st.cnt = 8'h00;
    end else if (st.cnt == 8'(`PIN_FILTER_CYC - 1)) begin
      next_st.level = !pin.rawPinN;
      next_st.cnt   = 8'h00;
    end else begin
      next_st.cnt = st.cnt + 8'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pin.pinActive = st.level;

endmodule
`default_nettype wire

//--- rtl/rc_osc_tune_failsafe_reset.sv
// fast internal oscillator trim, dither, fail-safe switch and reset sequencing
`timescale 1ns/1ps
`default_nettype none
`include "osc_tune_cfg.svh"
module rc_osc_tune_failsafe_reset #(
  parameter logic [22:0] PU_DELAY_4MS_CYC  = 23'(`PU_DELAY_CYC(`PU_DELAY_4_MS)),
  parameter logic [22:0] PU_DELAY_16MS_CYC = 23'(`PU_DELAY_CYC(`PU_DELAY_16_MS)),
  parameter logic [22:0] PU_DELAY_64MS_CYC = 23'(`PU_DELAY_CYC(`PU_DELAY_64_MS))
) (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        porPulse,
  input  wire logic [1:0]  oscGroupConfig,
  input  wire logic [1:0]  primaryModeConfig,
  input  wire logic [1:0]  switchMonitorConfig,
  input  wire logic [1:0]  powerUpDelaySel,
  input  wire logic        rangeSelect,
  input  wire logic [3:0]  trimField,
  input  wire logic [27:0] sequenceTrimSlots,
  input  wire logic        sequenceTrimEnable,
  input  wire logic        randomDitherEnable,
  input  wire logic        pwmRollover,
  input  wire logic        primaryClockOk,
  input  wire logic        switchRequestSet,
  input  wire logic        switchToPrimary,
  input  wire logic        clockFailClear,
  input  wire logic        extResetPinN,
  input  wire logic        inSleep,
  input  wire logic        watchdogTimeout,
  input  wire logic        resetInstr,
  input  wire logic        trapLockup,
  input  wire logic        illegalOp,
  input  wire logic [6:0]  causeClear,
  input  wire logic        firstPhaseClock,
  output logic             fastOscPower,
  output logic             oscRangeHigh,
  output logic [3:0]       appliedTrim,
  output logic [5:0]       rollCount,
  output logic [2:0]       currentOsc,
  output logic             clockFailFlag,
  output logic             switchRequestBit,
  output logic             clockFailTrap,
  output logic [23:0]      trapVector,
  output logic             primaryOscOff,
  output logic             systemReset,
  output logic [6:0]       resetCause,
  output logic             extResetPinOut,
  output logic             extResetPinOe
);

  osc_tune_pkg::ctrl_s st;
  osc_tune_pkg::ctrl_s next_st;
  reset_filter_if      pinIf ();

  logic switchEnable;
  logic monitorEnable;
  logic failDetect;
  logic [6:0] causeSet;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // slot 0 is the plain trim field, slots 1..7 the sequence registers
  function automatic logic [3:0] trim_mux(input logic [3:0]  base,
                                          input logic [27:0] slots,
                                          input logic [2:0]  sel);
    logic [3:0] r;
    r = base;
    if (sel != 3'h0) begin
      r = slots[4*(sel - 3'h1) +: 4];
    end
    return r;
  endfunction

  // configured power-up delay in cycles; 0 means no delay
  function automatic logic [22:0] pu_delay_cycles(input logic [1:0] sel);
    logic [22:0] r;
    unique case (sel)
      2'h0: r = 23'h000000;
      2'h1: r = PU_DELAY_4MS_CYC;
      2'h2: r = PU_DELAY_16MS_CYC;
      2'h3: r = PU_DELAY_64MS_CYC;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // reset pin filter

  assign pinIf.rawPinN = extResetPinN;

  reset_pin_filter u_filter (
    .ref_clk (ref_clk),
    .reset   (reset),
    .pin     (pinIf.filt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // configuration decode

  assign switchEnable  = !switchMonitorConfig[1];
  assign monitorEnable = (switchMonitorConfig == `SWM_ALL_ON);
  // a missing clock after the delay is caught the same way as a later loss
  assign failDetect = monitorEnable && st.currentOsc[1] && !primaryClockOk
                      && (st.rstState == osc_tune_pkg::RS_RUN);

  // causes other than power-up; pin in sleep also marks sleep
  always_comb begin
    causeSet = 7'h00;
    causeSet[`CAUSE_EXT]     = pinIf.pinActive;
    causeSet[`CAUSE_SLEEP]   = pinIf.pinActive && inSleep;
    causeSet[`CAUSE_WDOG]    = watchdogTimeout;
    causeSet[`CAUSE_SOFT]    = resetInstr;
    causeSet[`CAUSE_TRAP]    = trapLockup;
    causeSet[`CAUSE_ILLEGAL] = illegalOp;
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_st = st;
    next_st.trap   = 1'b0;
    next_st.pinOut = 1'b0;
    next_st.pinOe  = 1'b0;

    // period wrap counter
    if (pwmRollover) begin
      next_st.roll = st.roll + 6'h01;
    end
    // dither register steps once per eight PWM cycles
    if (next_st.roll[3] != st.roll[3]) begin
      next_st.lfsr = {st.lfsr[13:0], st.lfsr[14] ^ st.lfsr[13]};
    end

    // applied trim source
    if (randomDitherEnable) begin
      next_st.trim = st.lfsr[3:0];
    end else if (sequenceTrimEnable) begin
      next_st.trim = trim_mux(trimField, sequenceTrimSlots, st.roll[5:3]);
    end else begin
      next_st.trim = trimField;
    end
    next_st.rangeHigh = rangeSelect;

    // clock selection and fail-safe monitor
    if (!switchEnable) begin
      next_st.currentOsc = {1'b0, oscGroupConfig};
      next_st.switchReq  = 1'b0;
      next_st.failForced = 1'b0;
    end else if (failDetect) begin
      next_st.trap       = 1'b1;
      next_st.currentOsc = `OSC_FAST_RC;
      next_st.clockFail  = 1'b1;
      next_st.switchReq  = 1'b0;
      next_st.failForced = 1'b1;
      next_st.primaryOff = 1'b1;
    end else begin
      if (st.switchReq) begin
        // fuses fix the option inside the primary group; the internal group always gets the fast RC
        next_st.currentOsc = st.targetPrimary ?
                             {1'b0, 1'b1, oscGroupConfig[0]} : `OSC_FAST_RC;
        next_st.switchReq  = 1'b0;
        if (st.targetPrimary) begin
          next_st.primaryOff = 1'b0;
          next_st.failForced = 1'b0;
        end
      end
      if (switchRequestSet) begin
        next_st.switchReq     = 1'b1;
        next_st.targetPrimary = switchToPrimary;
      end
      if (clockFailClear) begin
        next_st.clockFail = 1'b0;
      end
    end

    // oscillator power: off only for external clock or crystal
    next_st.fastPower = !((primaryModeConfig == `PM_EXT_CLOCK) ||
                          (primaryModeConfig == `PM_CRYSTAL))
                        || next_st.failForced
                        || !next_st.currentOsc[1];

    // cause bits: hardware set wins over a clear in the same cycle
    next_st.cause = (st.cause & ~causeClear) | causeSet;

    // reset sequencer
    unique case (st.rstState)
      osc_tune_pkg::RS_BIAS: begin
        if (st.cnt == 23'(`BIAS_SETTLE_CYC - 1)) begin
          next_st.cnt      = 23'h000000;
          next_st.rstState = osc_tune_pkg::RS_DELAY;
        end else begin
          next_st.cnt = st.cnt + 23'h000001;
        end
      end
      osc_tune_pkg::RS_DELAY: begin
        if (st.cnt >= pu_delay_cycles(powerUpDelaySel)) begin
          next_st.rstState = osc_tune_pkg::RS_WAIT_PHASE;
        end else begin
          next_st.cnt = st.cnt + 23'h000001;
        end
      end
      osc_tune_pkg::RS_HOLD: begin
        if (!pinIf.pinActive) begin
          next_st.rstState = osc_tune_pkg::RS_WAIT_PHASE;
        end
      end
      osc_tune_pkg::RS_WAIT_PHASE: begin
        if (firstPhaseClock) begin
          next_st.system_reset   = 1'b0;
          next_st.rstState = osc_tune_pkg::RS_RUN;
        end
      end
      osc_tune_pkg::RS_RUN: begin
        next_st.system_reset = 1'b0;
      end
      default: begin
        next_st.rstState = osc_tune_pkg::RS_RUN;
      end
    endcase

    // any reset cause holds the core; the pin keeps holding while low
    if (causeSet != 7'h00) begin
      next_st.system_reset   = 1'b1;
      next_st.cnt      = 23'h000000;
      next_st.rstState = pinIf.pinActive ? osc_tune_pkg::RS_HOLD
                                         : osc_tune_pkg::RS_WAIT_PHASE;
    end

    // power-up restarts the reset sequence and fail-safe state (roll count and dither register keep their values) and takes the fuse clock
    if (porPulse) begin
      next_st.cause      = `CAUSE_POR_ONLY;
      next_st.system_reset     = 1'b1;
      next_st.cnt        = 23'h000000;
      next_st.rstState   = osc_tune_pkg::RS_BIAS;
      next_st.currentOsc = {1'b0, oscGroupConfig};
      next_st.clockFail  = 1'b0;
      next_st.switchReq  = 1'b0;
      next_st.failForced = 1'b0;
      next_st.primaryOff = 1'b0;
      next_st.trap       = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st            <= '0;
      st.lfsr       <= `LFSR_SEED;
      st.fastPower  <= 1'b1;
      st.currentOsc <= `OSC_FAST_RC;
      st.trapVector <= `CLOCK_FAIL_VEC;
      st.rstState   <= osc_tune_pkg::RS_BIAS;
      st.system_reset     <= 1'b1;
      st.cause      <= `CAUSE_POR_ONLY;
    end else begin
      st <= next_st;
    end
  end

  // every output is a field of the state register
  assign fastOscPower     = st.fastPower;
  assign oscRangeHigh     = st.rangeHigh;
  assign appliedTrim      = st.trim;
  assign rollCount        = st.roll;
  assign currentOsc       = st.currentOsc;
  assign clockFailFlag    = st.clockFail;
  assign switchRequestBit = st.switchReq;
  assign clockFailTrap    = st.trap;
  assign trapVector       = st.trapVector;
  assign primaryOscOff    = st.primaryOff;
  assign systemReset      = st.system_reset;
  assign resetCause       = st.cause;
  assign extResetPinOut   = st.pinOut;
  assign extResetPinOe    = st.pinOe;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  property p_fail_switch;
    failDetect && switchEnable && !porPulse |=> clockFailTrap
      && currentOsc == `OSC_FAST_RC && clockFailFlag && !switchRequestBit && fastOscPower;
  endproperty
  a_fail_switch: assert property (p_fail_switch) else $error("fail did not switch");

  property p_roll_inc;
    pwmRollover |=> rollCount == $past(rollCount) + 6'h01;
  endproperty
  a_roll_inc: assert property (p_roll_inc) else $error("roll count missed");

  property p_lfsr_pace;
    ##1 (rollCount[3] == $past(rollCount[3])) |-> $stable(st.lfsr);
  endproperty
  a_lfsr_pace: assert property (p_lfsr_pace) else $error("dither stepped early");

  property p_dither_first;
    randomDitherEnable |=> appliedTrim == $past(st.lfsr[3:0]);
  endproperty
  a_dither_first: assert property (p_dither_first) else $error("dither not applied");

  property p_seq_slot0;
    !randomDitherEnable && sequenceTrimEnable && rollCount[5:3] == 3'h0
      |=> appliedTrim == $past(trimField);
  endproperty
  a_seq_slot0: assert property (p_seq_slot0) else $error("slot zero wrong");

  property p_plain_trim;
    !randomDitherEnable && !sequenceTrimEnable |=> appliedTrim == $past(trimField);
  endproperty
  a_plain_trim: assert property (p_plain_trim) else $error("trim field ignored");

  property p_no_switch;
    switchMonitorConfig[1] && !porPulse |=> currentOsc == {1'b0, $past(oscGroupConfig)}
      && !clockFailTrap;
  endproperty
  a_no_switch: assert property (p_no_switch) else $error("switch while disabled");

  property p_por_flag;
    porPulse |=> resetCause == `CAUSE_POR_ONLY && systemReset;
  endproperty
  a_por_flag: assert property (p_por_flag) else $error("power-up flags wrong");

  property p_release;
    st.rstState == osc_tune_pkg::RS_WAIT_PHASE && firstPhaseClock
      && causeSet == 7'h00 && !porPulse |=> !systemReset ##1 !systemReset;
  endproperty
  a_release: assert property (p_release) else $error("release missed");

  property p_pin_quiet;
    ##1 $rose(systemReset) |-> !extResetPinOe;
  endproperty
  a_pin_quiet: assert property (p_pin_quiet) else $error("reset pin driven");

  c_fail_trap: cover property (clockFailTrap);
  c_seq_last: cover property (sequenceTrimEnable && rollCount[5:3] == 3'h7);
  c_release: cover property ($fell(systemReset));

endmodule
`default_nettype wire

//--- tb/pwm_core_model.sv
// behavioural pwm time base and core phase clock facing the oscillator block
`timescale 1ns/1ps
`default_nettype none
module pwm_core_model (
  input  wire logic ref_clk,
  output var logic  pwmRollover,
  output var logic  firstPhaseClock
);
  int phase = 0;
  initial pwmRollover = 1'b0;
  initial firstPhaseClock = 1'b0;
  // core phase clock: one leading-edge pulse every four cycles, free running
  always @(negedge ref_clk) begin
    phase = (phase + 1) % 4;
    firstPhaseClock <= (phase == 0);
  end
  // period wraps; gap stretches the period so both fast and slow time bases occur
  task automatic roll(input int n, input int gap);
    repeat (n) begin
      @(negedge ref_clk) pwmRollover = 1'b1;
      @(negedge ref_clk) pwmRollover = 1'b0;
      repeat (gap) @(negedge ref_clk);
    end
  endtask
endmodule
`default_nettype wire

//--- tb/rc_osc_tune_failsafe_reset_tb.sv
// self-checking bench for the oscillator trim, fail-safe switch and reset block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samplesChecked++; if ((g) !== (e)) begin fails++; \
  $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module rc_osc_tune_failsafe_reset_tb;
  logic        ref_clk, reset, porPulse, rangeSelect, sequenceTrimEnable, randomDitherEnable;
  logic        primaryClockOk, switchRequestSet, switchToPrimary, clockFailClear, extResetPinN;
  logic        inSleep, watchdogTimeout, resetInstr, trapLockup, illegalOp, pwmRollover;
  logic        firstPhaseClock, fastOscPower, oscRangeHigh, clockFailFlag, switchRequestBit;
  logic        clockFailTrap, primaryOscOff, systemReset, extResetPinOut, extResetPinOe;
  logic [1:0]  oscGroupConfig, primaryModeConfig, switchMonitorConfig, powerUpDelaySel;
  logic [3:0]  trimField, appliedTrim;
  logic [27:0] sequenceTrimSlots;
  logic [6:0]  causeClear, resetCause;
  logic [5:0]  rollCount;
  logic [2:0]  currentOsc;
  logic [23:0] trapVector;
  logic [31:0] rs = 32'h8B4F3F2E;
  int          fails = 0, samplesChecked = 0, mRoll = 0, mLfsr = 1;
  int          dly[4] = '{0, 20, 40, 80};

  // short power-up delays keep the run brief; expectations use the same figures
  rc_osc_tune_failsafe_reset #(.PU_DELAY_4MS_CYC(23'h14), .PU_DELAY_16MS_CYC(23'h28),
                               .PU_DELAY_64MS_CYC(23'h50)) i_dut (
    .ref_clk, .reset, .porPulse, .oscGroupConfig, .primaryModeConfig, .switchMonitorConfig,
    .powerUpDelaySel, .rangeSelect, .trimField, .sequenceTrimSlots, .sequenceTrimEnable,
    .randomDitherEnable, .pwmRollover, .primaryClockOk, .switchRequestSet, .switchToPrimary,
    .clockFailClear, .extResetPinN, .inSleep, .watchdogTimeout, .resetInstr, .trapLockup,
    .illegalOp, .causeClear, .firstPhaseClock, .fastOscPower, .oscRangeHigh, .appliedTrim,
    .rollCount, .currentOsc, .clockFailFlag, .switchRequestBit, .clockFailTrap, .trapVector,
    .primaryOscOff, .systemReset, .resetCause, .extResetPinOut, .extResetPinOe);
  pwm_core_model i_pwm (.ref_clk, .pwmRollover, .firstPhaseClock);

  initial ref_clk = 1'b0;
  always #5 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////////////////////////
  function logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction

  // reference trim: dither first, then the sequence slot, then the plain field
  function automatic logic [3:0] expTrim();
    int s;
    logic [3:0] q[$];
    s = (mRoll >> 3) & 7;
    q = {trimField};
    for (int k = 1; k < 8; k++) q.push_back(sequenceTrimSlots[4*k-1 -: 4]);
    if (randomDitherEnable) return 4'(mLfsr);
    if (!sequenceTrimEnable) return trimField;
    return q[s];
  endfunction

  // issue wraps and advance the reference; the lfsr moves only when roll bit 3 flips
  task automatic step(input int n, input int gap);
    int p;
    i_pwm.roll(n, gap);
    repeat (n) begin
      p = mRoll;
      mRoll = (mRoll + 1) % 64;
      if (((p ^ mRoll) & 8) != 0) mLfsr = ((mLfsr << 1) | (((mLfsr >> 14) ^ (mLfsr >> 13)) & 1)) & 32'h7FFF;
    end
    repeat (3) @(negedge ref_clk);
    `CHK("rollCount", 6'(mRoll), rollCount)
    `CHK("appliedTrim", expTrim(), appliedTrim)
  endtask

  task automatic waitRel(input int lim, output int c);
    c = 0;
    while (systemReset !== 1'b0 && c < lim) begin
      @(negedge ref_clk);
      c++;
    end
    `CHK("releaseInTime", 1'b1, c < lim)
  endtask

  task automatic doReset();
    int c;
    @(negedge ref_clk) reset = 1'b1;
    @(negedge ref_clk) reset = 1'b0;
    mRoll = 0;
    mLfsr = 1;
    waitRel(1200, c);
  endtask

  task automatic pulse(ref logic s);
    @(negedge ref_clk) s = 1'b1;
    @(negedge ref_clk) s = 1'b0;
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", samplesChecked, fails);
    if (fails == 0 && samplesChecked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // watchdog: the tests need well under 20000 cycles
  initial begin
    #300000;
    fails++;
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int c, t;
    {reset, porPulse, rangeSelect, sequenceTrimEnable, randomDitherEnable} = 5'h10;
    {switchRequestSet, switchToPrimary, clockFailClear, inSleep, watchdogTimeout} = 5'h00;
    {resetInstr, trapLockup, illegalOp, primaryClockOk, extResetPinN} = 5'h03;
    {oscGroupConfig, primaryModeConfig, switchMonitorConfig, powerUpDelaySel} = 8'hAE;
    trimField = 4'h0;
    sequenceTrimSlots = 28'h0;
    causeClear = 7'h00;
    repeat (3) @(negedge ref_clk);
    reset = 1'b0;
    // every power-up delay choice, restarted by the power-up pulse
    for (int s = 0; s < 4; s++) begin
      powerUpDelaySel = 2'(s);
      pulse(porPulse);
      waitRel(1200, c);
      `CHK("powerUpCycles", 1'b1, c >= 998 + dly[s] && c <= 1008 + dly[s])
      `CHK("porCause", 7'h01, resetCause)
    end
    powerUpDelaySel = 2'h0;
    $display("test power-up delay done");
    // plain field, then all eight sequence slots across a roll wrap
    trimField = 4'(xs());
    sequenceTrimSlots = 28'(xs());
    step(2, 1);
    sequenceTrimEnable = 1'b1;
    for (int i = 0; i < 20; i++) step(4, i % 3);
    for (int r = 0; r < 2; r++) begin
      rangeSelect = 1'(r);
      repeat (3) @(negedge ref_clk);
      `CHK("oscRangeHigh", 1'(r), oscRangeHigh)
    end
    $display("test trim sequencing done");
    // dither over sequencing; odd wrap counts check that no step happens without a flip
    randomDitherEnable = 1'b1;
    doReset();
    for (int i = 0; i < 14; i++) step(3 + i % 6, i % 2);
    randomDitherEnable = 1'b0;
    step(1, 0);
    $display("test dither done");
    // oscillator power per primary mode, primary group fused
    for (int m = 0; m < 4; m++) begin
      primaryModeConfig = 2'(m);
      repeat (3) @(negedge ref_clk);
      `CHK("fastOscPower", 1'(m == 1 || m == 3), fastOscPower)
    end
    // switching off: requests ignored and the field mirrors the fuses
    for (int g = 0; g < 4; g++) begin
      oscGroupConfig = 2'(g);
      switchToPrimary = 1'(g == 0);
      pulse(switchRequestSet);
      repeat (3) @(negedge ref_clk);
      `CHK("currentOsc", {1'b0, 2'(g)}, currentOsc)
    end
    // switching only, monitor off: a dead primary must not trap
    switchMonitorConfig = 2'h1;
    // to primary, over to the internal group, and back to primary
    for (int p = 0; p < 3; p++) begin
      switchToPrimary = 1'(p != 1);
      pulse(switchRequestSet);
      repeat (4) @(negedge ref_clk);
      `CHK("currentOsc", (p == 1) ? 3'h0 : 3'h3, currentOsc)
      `CHK("switchRequestBit", 1'b0, switchRequestBit)
    end
    // crystal mode, so the fast oscillator is powered only by the forced switch
    primaryModeConfig = 2'h2;
    // the primary is stopped only here, on purpose, never slowed below 100 kHz otherwise
    for (int k = 0; k < 2; k++) begin
      switchMonitorConfig = 2'(k == 0);
      primaryClockOk = 1'b0;
      t = 0;
      repeat (10) @(negedge ref_clk) t += int'(clockFailTrap === 1'b1);
      `CHK("trapPulses", k, t)
      `CHK("fastOscPower", 1'(k), fastOscPower)
    end
    `CHK("currentOsc", 3'h0, currentOsc)
    `CHK("clockFailFlag", 1'b1, clockFailFlag)
    `CHK("switchRequestBit", 1'b0, switchRequestBit)
    `CHK("primaryOscOff", 1'b1, primaryOscOff)
    `CHK("trapVector", 24'h000004, trapVector)
    `CHK("fastOscPower", 1'b1, fastOscPower)
    $display("test fail-safe switch done");
    // reset causes from inside; watchdog first, while the primary is still dead
    for (int k = 3; k < 7; k++) begin
      @(negedge ref_clk) causeClear = 7'h7F;
      @(negedge ref_clk) causeClear = 7'h00;
      case (k)
        3: watchdogTimeout = 1'b1;
        4: resetInstr = 1'b1;
        5: trapLockup = 1'b1;
        default: illegalOp = 1'b1;
      endcase
      @(negedge ref_clk);
      {watchdogTimeout, resetInstr, trapLockup, illegalOp} = 4'h0;
      primaryClockOk = 1'b1;
      `CHK("heldInReset", 1'b1, systemReset)
      `CHK("resetCause", 7'(1 << k), resetCause)
      `CHK("pinOe", 1'b0, extResetPinOe)
      `CHK("pinOut", 1'b0, extResetPinOut)
      waitRel(40, c);
    end
    pulse(clockFailClear);
    @(negedge ref_clk);
    `CHK("clockFailFlag", 1'b0, clockFailFlag)
    // a short glitch on the pin is ignored, a long low resets, in run and in sleep
    extResetPinN = 1'b0;
    repeat (10) @(negedge ref_clk);
    extResetPinN = 1'b1;
    repeat (3) @(negedge ref_clk);
    `CHK("glitchIgnored", 1'b0, systemReset)
    for (int s = 0; s < 2; s++) begin
      @(negedge ref_clk) causeClear = 7'h7F;
      @(negedge ref_clk) causeClear = 7'h00;
      inSleep = 1'(s);
      extResetPinN = 1'b0;
      repeat (30) @(negedge ref_clk);
      `CHK("pinHeld", 1'b1, systemReset)
      extResetPinN = 1'b1;
      inSleep = 1'b0;
      waitRel(40, c);
      `CHK("pinCause", (s == 1) ? 7'h06 : 7'h02, resetCause)
    end
    $display("test reset causes done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
